// [addr_decode_pkg.sv]
package addr_decode_pkg;

    // register file space
    localparam int RF_AW = 12;
    localparam int RAM_BYTES = 1024;
    localparam int RAM_AW = 10;
    localparam logic [11:0] RF_RAM_LIMIT = 12'h400;
    localparam logic [11:0] RF_CTRL_BASE = 12'hf00;
    localparam int CTRL_AW = 8;
    localparam logic [7:0] RF_UNDEF_DATA = 8'h00;

    // program and data memory spaces
    localparam int MEM_AW = 16;
    localparam int FLASH_MIN_BYTES = 4096;
    localparam int FLASH_MAX_BYTES = 8192;
    localparam logic [7:0] PM_UNIMPL_DATA = 8'hff;

    // port a pin positions of the alternate functions; port b analog and port c pin counts
    localparam int PA_TIMER_IN = 0;
    localparam int PA_TIMER_OUT = 1;
    localparam int PA_DRIVER_EN = 2;
    localparam int PA_CLEAR_TO_SEND = 3;
    localparam int PA_RECEIVE = 4;
    localparam int PA_TRANSMIT = 5;
    localparam int PA_BUS_CLOCK = 6;
    localparam int PA_BUS_DATA = 7;
    localparam int PB_ANALOG_N = 5;
    localparam int PC_PINS = 6;

    // level seen out of reset by a port a peripheral input whose pin is not routed to it
    localparam logic PERIPH_IDLE = 1'b1;

    typedef struct packed {
        logic valid;
        logic write;
        logic [RF_AW-1:0] addr;
        logic [7:0] wdata;
    } rf_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [CTRL_AW-1:0] addr;
        logic [7:0] wdata;
    } ctrl_req_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [MEM_AW-1:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic [7:0] out_data;
        logic [7:0] dir_out;
        logic [7:0] alt_en;
        logic [7:0] open_drain;
    } port_cfg_t;

    typedef struct packed {
        logic [RAM_BYTES-1:0][7:0] ram;
        logic sel_ram;
        logic sel_ctrl;
        logic sel_unimpl;
        logic rf_rd;
        logic [7:0] ram_q;
        logic rf_ack;
        logic [7:0] rf_rdata;
        ctrl_req_t ctrl_req;
        mem_req_t flash_req;
        logic pm_pend;
        logic pm_hit;
        logic pm_rd;
        logic pm_ack;
        logic [7:0] pm_rdata;
        mem_req_t dm_req;
        logic dm_ack;
        logic [7:0] dm_rdata;
        logic [7:0] pa_out;
        logic [7:0] pa_oe;
        logic [PB_ANALOG_N-1:0] pb_out;
        logic [PB_ANALOG_N-1:0] pb_oe;
        logic [PC_PINS-1:0] pc_out;
        logic [PC_PINS-1:0] pc_oe;
        logic timer_in;
        logic cts;
        logic rx;
        logic scl_in;
        logic sda_in;
        logic [PB_ANALOG_N-1:0] analog;
    } decoder_state_t;

    localparam decoder_state_t STATE_RESET = '0;

endpackage

// [addr_space_decoder.sv]
`timescale 1ns/100ps
module addr_space_decoder
    import addr_decode_pkg::*;
#(
    parameter int FLASH_BYTES = FLASH_MAX_BYTES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire rf_req_t rf_req,
    output logic rf_ack,
    output logic [7:0] rf_rdata,
    output logic sel_ram,
    output logic sel_ctrl,
    output logic sel_unimpl,
    output ctrl_req_t ctrl_req,
    input wire logic [7:0] ctrl_rdata,
    input wire mem_req_t pm_req,
    output logic pm_ack,
    output logic [7:0] pm_rdata,
    output mem_req_t flash_req,
    input wire logic [7:0] flash_rdata,
    input wire mem_req_t dm_req_in,
    output logic dm_ack,
    output logic [7:0] dm_rdata,
    output mem_req_t dm_req,
    input wire logic [7:0] dm_mem_rdata,
    input wire port_cfg_t port_a_cfg,
    input wire port_cfg_t port_b_cfg,
    input wire port_cfg_t port_c_cfg,
    input wire logic [7:0] port_a_pins_in,
    output logic [7:0] port_a_pins_out,
    output logic [7:0] port_a_pins_oe,
    input wire logic [PB_ANALOG_N-1:0] port_b_pins_in,
    output logic [PB_ANALOG_N-1:0] port_b_pins_out,
    output logic [PB_ANALOG_N-1:0] port_b_pins_oe,
    output logic [PC_PINS-1:0] port_c_pins_out,
    output logic [PC_PINS-1:0] port_c_pins_oe,
    output logic timer0_input_pin,
    input wire logic timer0_output_pin,
    input wire logic uart_driver_enable_pin,
    output logic uart_clear_to_send_pin,
    output logic uart_ir_receive_pin,
    input wire logic uart_ir_transmit_pin,
    output logic bus_clock_in,
    input wire logic bus_clock_out,
    output logic bus_data_in,
    input wire logic bus_data_out,
    output logic [PB_ANALOG_N-1:0] analog_input
);

    localparam logic [MEM_AW:0] FLASH_LIMIT = (MEM_AW+1)'(FLASH_BYTES);

    decoder_state_t s_r;
    decoder_state_t s_nxt;

    // returns {oe, out}; an open-drain pin releases rather than drives a one
    // an open-drain pin shows 0 on out, so a one never reaches the wire even if oe is misread
    function automatic logic [1:0] drive(input logic data, input logic od);
        return {(~od | ~data), data & ~od};
    endfunction

    always_comb begin
        logic [1:0] d;
        d = 2'b00;
        s_nxt = s_r;

        // stage 1: register file decode, one region per access
        s_nxt.sel_ram = 1'b0;
        s_nxt.sel_ctrl = 1'b0;
        s_nxt.sel_unimpl = 1'b0;
        s_nxt.rf_rd = rf_req.valid & ~rf_req.write;
        s_nxt.ctrl_req = '0;
        if (rf_req.valid) begin
            if (rf_req.addr >= RF_CTRL_BASE) begin
                // reserved page locations are passed through; software keeps off them
                s_nxt.sel_ctrl = 1'b1;
                s_nxt.ctrl_req.valid = 1'b1;
                s_nxt.ctrl_req.write = rf_req.write;
                s_nxt.ctrl_req.addr = rf_req.addr[CTRL_AW-1:0];
                s_nxt.ctrl_req.wdata = rf_req.wdata;
            end else if (rf_req.addr < RF_RAM_LIMIT) begin
                s_nxt.sel_ram = 1'b1;
                // ram sits in flops so a read always answers two cycles after the request; area traded for fixed latency
                if (rf_req.write) begin
                    s_nxt.ram[rf_req.addr[RAM_AW-1:0]] = rf_req.wdata;
                end else begin
                    s_nxt.ram_q = s_r.ram[rf_req.addr[RAM_AW-1:0]];
                end
            end else begin
                s_nxt.sel_unimpl = 1'b1;
            end
        end

        // stage 2: register file answer
        // page read data is taken while ctrl_req still stands, one cycle after the select
        s_nxt.rf_ack = s_r.sel_ram | s_r.sel_ctrl | s_r.sel_unimpl;
        if (s_r.rf_rd) begin
            if (s_r.sel_ram) begin
                s_nxt.rf_rdata = s_r.ram_q;
            end else if (s_r.sel_ctrl) begin
                s_nxt.rf_rdata = ctrl_rdata;
            end else begin
                s_nxt.rf_rdata = RF_UNDEF_DATA;
            end
        end

        // program memory, decoded apart from the register file
        s_nxt.flash_req = '0;
        s_nxt.pm_pend = pm_req.valid;
        s_nxt.pm_rd = pm_req.valid & ~pm_req.write;
        // the hit flag rides along with the request, so the answer stage needs no second compare
        s_nxt.pm_hit = ({1'b0, pm_req.addr} < FLASH_LIMIT);
        if (pm_req.valid && s_nxt.pm_hit) begin
            s_nxt.flash_req = pm_req;
        end
        s_nxt.pm_ack = s_r.pm_pend;
        if (s_r.pm_rd) begin
            s_nxt.pm_rdata = s_r.pm_hit ? flash_rdata : PM_UNIMPL_DATA;
        end

        // data memory, its own space
        s_nxt.dm_req = dm_req_in;
        s_nxt.dm_ack = s_r.dm_req.valid;
        if (s_r.dm_req.valid && !s_r.dm_req.write) begin
            s_nxt.dm_rdata = dm_mem_rdata;
        end

        // port a
        for (int i = 0; i < 8; i++) begin
            d = 2'b00;
            if (port_a_cfg.alt_en[i]) begin
                case (i)
                    PA_TIMER_OUT: d = drive(timer0_output_pin, port_a_cfg.open_drain[i]);
                    PA_DRIVER_EN: d = drive(uart_driver_enable_pin, port_a_cfg.open_drain[i]);
                    PA_TRANSMIT: d = drive(uart_ir_transmit_pin, port_a_cfg.open_drain[i]);
                    // bus pins ignore open_drain: a driven high would fight other devices on the wire
                    PA_BUS_CLOCK: d = drive(bus_clock_out, 1'b1);
                    PA_BUS_DATA: d = drive(bus_data_out, 1'b1);
                    default: d = 2'b00;
                endcase
            end else if (port_a_cfg.dir_out[i]) begin
                d = drive(port_a_cfg.out_data[i], port_a_cfg.open_drain[i]);
            end
            s_nxt.pa_oe[i] = d[1];
            s_nxt.pa_out[i] = d[0];
        end
        // an input not routed to its pin idles high after reset, the resting level of those lines; reset holds it low
        s_nxt.timer_in = port_a_cfg.alt_en[PA_TIMER_IN] ? port_a_pins_in[PA_TIMER_IN] : PERIPH_IDLE;
        s_nxt.cts = port_a_cfg.alt_en[PA_CLEAR_TO_SEND] ? port_a_pins_in[PA_CLEAR_TO_SEND] : PERIPH_IDLE;
        s_nxt.rx = port_a_cfg.alt_en[PA_RECEIVE] ? port_a_pins_in[PA_RECEIVE] : PERIPH_IDLE;
        s_nxt.scl_in = port_a_cfg.alt_en[PA_BUS_CLOCK] ? port_a_pins_in[PA_BUS_CLOCK] : PERIPH_IDLE;
        s_nxt.sda_in = port_a_cfg.alt_en[PA_BUS_DATA] ? port_a_pins_in[PA_BUS_DATA] : PERIPH_IDLE;

        // port b: an analog pin has its driver off
        for (int i = 0; i < PB_ANALOG_N; i++) begin
            d = 2'b00;
            if (!port_b_cfg.alt_en[i] && port_b_cfg.dir_out[i]) begin
                d = drive(port_b_cfg.out_data[i], port_b_cfg.open_drain[i]);
            end
            s_nxt.pb_oe[i] = d[1];
            s_nxt.pb_out[i] = d[0];
            s_nxt.analog[i] = port_b_cfg.alt_en[i] & port_b_pins_in[i];
        end

        // port c: no alternate functions here
        for (int i = 0; i < PC_PINS; i++) begin
            d = 2'b00;
            if (!port_c_cfg.alt_en[i] && port_c_cfg.dir_out[i]) begin
                d = drive(port_c_cfg.out_data[i], port_c_cfg.open_drain[i]);
            end
            s_nxt.pc_oe[i] = d[1];
            s_nxt.pc_out[i] = d[0];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rf_ack = s_r.rf_ack;
    assign rf_rdata = s_r.rf_rdata;
    assign sel_ram = s_r.sel_ram;
    assign sel_ctrl = s_r.sel_ctrl;
    assign sel_unimpl = s_r.sel_unimpl;
    assign ctrl_req = s_r.ctrl_req;
    assign pm_ack = s_r.pm_ack;
    assign pm_rdata = s_r.pm_rdata;
    assign flash_req = s_r.flash_req;
    assign dm_ack = s_r.dm_ack;
    assign dm_rdata = s_r.dm_rdata;
    assign dm_req = s_r.dm_req;
    assign port_a_pins_out = s_r.pa_out;
    assign port_a_pins_oe = s_r.pa_oe;
    assign port_b_pins_out = s_r.pb_out;
    assign port_b_pins_oe = s_r.pb_oe;
    assign port_c_pins_out = s_r.pc_out;
    assign port_c_pins_oe = s_r.pc_oe;
    assign timer0_input_pin = s_r.timer_in;
    assign uart_clear_to_send_pin = s_r.cts;
    assign uart_ir_receive_pin = s_r.rx;
    assign bus_clock_in = s_r.scl_in;
    assign bus_data_in = s_r.sda_in;
    assign analog_input = s_r.analog;

endmodule

// [addr_space_monitor.sv]
`timescale 1ns/100ps
module addr_space_monitor
    import addr_decode_pkg::*;
#(parameter int FLASH_BYTES = FLASH_MAX_BYTES) (
    input wire logic clock,
    input wire logic rst_b,
    input wire rf_req_t rf_req,
    input wire logic sel_ram,
    input wire logic sel_ctrl,
    input wire logic sel_unimpl,
    input wire ctrl_req_t ctrl_req,
    input wire mem_req_t pm_req,
    input wire logic pm_ack,
    input wire logic [7:0] pm_rdata,
    input wire mem_req_t flash_req,
    input wire mem_req_t dm_req_in,
    input wire mem_req_t dm_req,
    input wire port_cfg_t port_a_cfg,
    input wire logic [7:0] port_a_pins_out,
    input wire logic [7:0] port_a_pins_oe,
    input wire logic bus_clock_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_sel;
        rf_req.valid |=> $onehot({sel_ram, sel_ctrl, sel_unimpl});
    endproperty
    a_sel: assert property (p_sel) else $error("region select");
    property p_ram;
        rf_req.valid && rf_req.addr < RF_RAM_LIMIT |=> sel_ram;
    endproperty
    a_ram: assert property (p_ram) else $error("ram select");
    property p_ctrl;
        rf_req.valid && rf_req.addr >= RF_CTRL_BASE |=> ctrl_req.valid && ctrl_req.addr == $past(rf_req.addr[7:0]);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control page");
    property p_gap;
        rf_req.valid && rf_req.addr >= RF_RAM_LIMIT && rf_req.addr < RF_CTRL_BASE |=> sel_unimpl && !ctrl_req.valid;
    endproperty
    a_gap: assert property (p_gap) else $error("gap access");
    property p_pm;
        pm_req.valid && !pm_req.write && pm_req.addr >= FLASH_BYTES |-> ##2 pm_ack && pm_rdata == PM_UNIMPL_DATA;
    endproperty
    a_pm: assert property (p_pm) else $error("unimplemented read");
    property p_drop;
        pm_req.valid && pm_req.addr >= FLASH_BYTES |=> !flash_req.valid;
    endproperty
    a_drop: assert property (p_drop) else $error("flash forwarded");
    property p_dm;
        dm_req_in.valid |=> dm_req == $past(dm_req_in);
    endproperty
    a_dm: assert property (p_dm) else $error("data request");
    property p_od;
        port_a_cfg.alt_en[7] |=> !port_a_pins_out[7];
    endproperty
    a_od: assert property (p_od) else $error("bus data drive");
    property p_scl;
        port_a_cfg.alt_en[6] |=> port_a_pins_oe[6] == !$past(bus_clock_out);
    endproperty
    a_scl: assert property (p_scl) else $error("bus clock drive");
endmodule

// [core_side_mem.sv]
`timescale 1ns/100ps
module core_side_mem
    import addr_decode_pkg::*;
(
    input wire logic clock,
    input wire mem_req_t flash_req,
    input wire ctrl_req_t ctrl_req,
    input wire mem_req_t dm_req,
    output logic [7:0] flash_rdata,
    output logic [7:0] ctrl_rdata,
    output logic [7:0] dm_mem_rdata
);
    // unselected lines churn so a stale value never passes
    logic [7:0] churn = 8'h00;
    always @(posedge clock) churn <= churn + 8'h3b;
    assign flash_rdata = flash_req.valid ? flash_req.addr[7:0] ^ 8'ha5 : churn;
    assign ctrl_rdata = ctrl_req.valid ? ctrl_req.addr ^ 8'h3c : ~churn;
    assign dm_mem_rdata = dm_req.valid ? dm_req.addr[7:0] ^ 8'h69 : churn ^ 8'h55;
endmodule

// [tb.sv]
`timescale 1ns/100ps
module tb;
    import addr_decode_pkg::*;
    localparam int FB = 4096;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    rf_req_t rf_req = '0;
    mem_req_t pm_req = '0, dm_req_in = '0, flash_req, dm_req;
    ctrl_req_t ctrl_req;
    port_cfg_t port_a_cfg = '0, port_b_cfg = '0, port_c_cfg = '0;
    logic rf_ack, pm_ack, dm_ack, sel_ram, sel_ctrl, sel_unimpl, timer0_input_pin, uart_clear_to_send_pin;
    logic uart_ir_receive_pin, bus_clock_in, bus_data_in, timer0_output_pin = 0, uart_driver_enable_pin = 0;
    logic uart_ir_transmit_pin = 0, bus_clock_out = 0, bus_data_out = 0;
    logic [7:0] rf_rdata, pm_rdata, dm_rdata, ctrl_rdata, flash_rdata, dm_mem_rdata, port_a_pins_out;
    logic [7:0] port_a_pins_oe, port_a_pins_in = '0;
    logic [PB_ANALOG_N-1:0] port_b_pins_in = '0, port_b_pins_out, port_b_pins_oe, analog_input;
    logic [PC_PINS-1:0] port_c_pins_out, port_c_pins_oe;
    logic [7:0] ram_m [RAM_BYTES] = '{default: 8'h00};
    logic [31:0] r;
    int n_errors = 0, cmp_count = 0, seed = 32'hb887;
    always #4 clock = ~clock;
    addr_space_decoder #(.FLASH_BYTES(FB)) u_dut (.*);
    core_side_mem u_mem (.*);
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask
    task tally_and_finish;
        if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic exp_oe(port_cfg_t c, int i);
        return !c.alt_en[i] && c.dir_out[i] && !(c.open_drain[i] && c.out_data[i]);
    endfunction
    // per holds {timer out, driver enable, transmit, bus clock, bus data}; pa marks port a
    function automatic logic [1:0] exp_pin(port_cfg_t c, logic [4:0] per, int i, logic pa);
        logic v;
        logic od;
        v = c.out_data[i];
        od = c.open_drain[i];
        if (c.alt_en[i] && pa) begin
            case (i)
                PA_TIMER_OUT: v = per[4];
                PA_DRIVER_EN: v = per[3];
                PA_TRANSMIT: v = per[2];
                PA_BUS_CLOCK: v = per[1];
                PA_BUS_DATA: v = per[0];
                default: return 2'b00;
            endcase
            if (i >= PA_BUS_CLOCK) od = 1'b1;
        end else if (c.alt_en[i] || !c.dir_out[i]) begin
            return 2'b00;
        end
        return (od && v) ? 2'b00 : {1'b1, v};
    endfunction
    task automatic rf_op(input logic w, input logic [11:0] a, input logic [7:0] d);
        logic [7:0] e;
        e = a < RF_RAM_LIMIT ? ram_m[a[9:0]] : a >= RF_CTRL_BASE ? a[7:0] ^ 8'h3c : RF_UNDEF_DATA;
        if (w && a < RF_RAM_LIMIT) ram_m[a[9:0]] = d;
        rf_req <= '{1'b1, w, a, d};
        @(posedge clock);
        rf_req.valid <= 1'b0;
        @(posedge clock);
        #1;
        chk1("rf_ack", 1'b1, rf_ack);
        if (!w) chk8("rf_rdata", e, rf_rdata);
        @(posedge clock);
    endtask
    task automatic mem_op(input logic dm, input logic w, input logic [15:0] a);
        logic [7:0] e;
        e = dm ? a[7:0] ^ 8'h69 : a < FB ? a[7:0] ^ 8'ha5 : PM_UNIMPL_DATA;
        if (dm) dm_req_in <= '{1'b1, w, a, 8'h00};
        else pm_req <= '{1'b1, w, a, 8'h00};
        @(posedge clock);
        dm_req_in.valid <= 1'b0;
        pm_req.valid <= 1'b0;
        @(posedge clock);
        #1;
        chk1("mem_ack", 1'b1, dm ? dm_ack : pm_ack);
        if (!w) chk8("mem_rdata", e, dm ? dm_rdata : pm_rdata);
        @(posedge clock);
    endtask
    task automatic pin_op;
        port_cfg_t ca;
        port_cfg_t cc;
        logic [1:0] p;
        ca = $random(seed);
        cc = $random(seed);
        r = $random(seed);
        port_a_cfg <= ca;
        port_b_cfg <= r;
        port_c_cfg <= cc;
        port_a_pins_in <= cc.open_drain;
        port_b_pins_in <= r[28:24];
        {timer0_output_pin, uart_driver_enable_pin, uart_ir_transmit_pin, bus_clock_out, bus_data_out} <= r[20:16];
        @(posedge clock);
        #1;
        chk8("analog", {3'b000, r[28:24] & r[12:8]}, {3'b000, analog_input});
        chk1("timer_in", ca.alt_en[0] ? cc.open_drain[0] : 1'b1, timer0_input_pin);
        chk1("rx_in", ca.alt_en[4] ? cc.open_drain[4] : 1'b1, uart_ir_receive_pin);
        chk1("scl_oe", ca.alt_en[6] ? ~r[17] : exp_oe(ca, 6), port_a_pins_oe[6]);
        chk1("pa3_oe", exp_oe(ca, 3), port_a_pins_oe[3]);
        chk1("pc0_oe", exp_oe(cc, 0), port_c_pins_oe[0]);
        chk1("cts_in", ca.alt_en[3] ? cc.open_drain[3] : 1'b1, uart_clear_to_send_pin);
        chk1("scl_in", ca.alt_en[6] ? cc.open_drain[6] : 1'b1, bus_clock_in);
        chk1("sda_in", ca.alt_en[7] ? cc.open_drain[7] : 1'b1, bus_data_in);
        for (int i = 0; i < 8; i++) begin
            p = exp_pin(ca, r[20:16], i, 1'b1);
            chk8("pa_pin", {6'h00, p}, {6'h00, port_a_pins_oe[i], port_a_pins_out[i]});
        end
        for (int i = 0; i < PB_ANALOG_N; i++) begin
            p = exp_pin(r, r[20:16], i, 1'b0);
            chk8("pb_pin", {6'h00, p}, {6'h00, port_b_pins_oe[i], port_b_pins_out[i]});
        end
        for (int i = 0; i < PC_PINS; i++) begin
            p = exp_pin(cc, r[20:16], i, 1'b0);
            chk8("pc_pin", {6'h00, p}, {6'h00, port_c_pins_oe[i], port_c_pins_out[i]});
        end
        @(posedge clock);
    endtask
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rf_op(1'b1, 12'h3ff, 8'h5a);
        rf_op(1'b0, 12'h3ff, 8'h00);
        rf_op(1'b1, 12'h400, 8'h77);
        rf_op(1'b0, 12'h000, 8'h00);
        rf_op(1'b0, 12'heff, 8'h00);
        rf_op(1'b1, 12'hf00, 8'h11);
        rf_op(1'b0, 12'hfff, 8'h00);
        mem_op(1'b0, 1'b0, 16'h0fff);
        mem_op(1'b0, 1'b1, 16'h1000);
        mem_op(1'b0, 1'b0, 16'hffff);
        mem_op(1'b1, 1'b1, 16'h1000);
        repeat (300) begin
            r = $random(seed);
            rf_op(r[12], r[31] ? {2'b00, r[9:0]} : r[11:0], r[20:13]);
            mem_op(r[21], r[22], r[30:15]);
            pin_op();
        end
        // second reset in mid-run: outputs drop at once, ram is cleared
        rst_b <= 1'b0;
        port_a_cfg <= '0;
        #1;
        chk8("rst_pa_oe", 8'h00, port_a_pins_oe);
        chk1("rst_ack", 1'b0, rf_ack);
        chk1("rst_timer_in", 1'b0, timer0_input_pin);
        @(posedge clock);
        rst_b <= 1'b1;
        ram_m = '{default: 8'h00};
        @(posedge clock);
        rf_op(1'b0, 12'h3ff, 8'h00);
        rf_op(1'b0, 12'hf20, 8'h00);
        tally_and_finish();
    end
endmodule
bind addr_space_decoder addr_space_monitor #(.FLASH_BYTES(FLASH_BYTES)) u_mon (.*);
